// File: verilog/alu_sleep_pkg.sv
/*
  Constants and types shared by the instruction execution block.
  Assumes a 32-bit classic Wishbone bus with byte addresses.
*/
package alu_sleep_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [9:0] ADR_ACC = 10'h000;
  localparam logic [9:0] ADR_STATUS = 10'h004;
  localparam logic [9:0] ADR_INSTR = 10'h008;
  localparam logic [9:0] ADR_DIR_A = 10'h00C;
  localparam logic [9:0] ADR_DIR_B = 10'h010;
  localparam logic [9:0] ADR_DIR_C = 10'h014;
  localparam logic [9:0] ADR_WDT = 10'h018;
  localparam logic [9:0] ADR_FILE_BASE = 10'h200;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int ST_CARRY = 0;
  localparam int ST_DIGIT = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  localparam int ST_SLEEP = 5;

  // ----------------------------------------------------------------
  // Instruction register fields and operation codes
  // ----------------------------------------------------------------
  localparam int IN_OP_LSB = 0;
  localparam int IN_DEST = 4;
  localparam int IN_OPND_LSB = 8;
  localparam logic [3:0] OP_ROTATE_RIGHT = 4'h0;
  localparam logic [3:0] OP_LIT_MINUS_ACC = 4'h1;
  localparam logic [3:0] OP_REG_MINUS_ACC = 4'h2;
  localparam logic [3:0] OP_REG_MINUS_ACC_B = 4'h3;
  localparam logic [3:0] OP_NIBBLE_EXCHANGE = 4'h4;
  localparam logic [3:0] OP_LOAD_DIRECTION = 4'h5;
  localparam logic [3:0] OP_XOR_LITERAL = 4'h6;
  localparam logic [3:0] OP_XOR_REGISTER = 4'h7;
  localparam logic [3:0] OP_SLEEP = 4'h8;
  localparam logic [7:0] DIR_SEL_A = 8'h05;
  localparam logic [7:0] DIR_SEL_B = 8'h06;
  localparam logic [7:0] DIR_SEL_C = 8'h07;
  localparam logic DEST_ACC = 1'b0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hFF;
  localparam logic RST_TO = 1'b1;
  localparam logic RST_PD = 1'b1;
  localparam logic RST_OSC_RUN = 1'b1;
  localparam logic [7:0] WDT_CLEAR = 8'h00;

  typedef struct packed {
    logic [2:0] wake_sync;
    logic sleep;
    logic osc_run;
    logic [7:0] acc;
    logic carry;
    logic digit_carry_flag;
    logic zero;
    logic timeout_status_bit;
    logic powerdown_status_bit;
    logic [7:0] port_a_direction;
    logic [7:0] port_b_direction;
    logic [7:0] port_c_direction;
    logic [7:0] watchdog_counter;
    logic [7:0] prescaler;
    logic ack;
    logic [31:0] dat;
  } state_t;

  typedef struct packed {
    logic [7:0] operand;
    logic dest;
    logic [3:0] op;
  } instr_t;

endpackage

// File: verilog/alu_sleep.sv
/*
  Instruction execution block: rotate, subtract, swap, xor, direction
  load and sleep entry, with a Wishbone register file in front.
  Assumes a classic Wishbone master on clk_i and a wake pin from outside.
*/
// How it works
// - Rotate right moves old carry into bit 7 and bit 0 into carry.
// - Destination bit 0 writes the accumulator, 1 the file register.
// - Sleep clears watchdog and prescaler, sets timeout, clears power-down.
// - After sleep execution stops and the oscillator halts until wake.
// - Literal minus accumulator goes to the accumulator.
// - Subtracts set carry and digit carry unless a borrow, and zero.
// - Register minus accumulator is routed by the destination bit.
// - Subtract with borrow also takes away the inverted carry.
// - Nibble exchange swaps the halves and leaves all flags alone.
// - Direction load takes operand 5 to 7 for ports A to C only.
// - Xor literal writes the accumulator and touches only zero.
// - Xor register is routed by the destination bit, zero only.
`timescale 1ns/1ns
module alu_sleep #(
  parameter int FILE_DEPTH = 128
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins
  input wire logic wake_i,
  output logic osc_run_o,
  output logic [7:0] port_a_direction_o,
  output logic [7:0] port_b_direction_o,
  output logic [7:0] port_c_direction_o
);

  // ----------------------------------------------------------------
  // Checks and storage
  // ----------------------------------------------------------------
  if (FILE_DEPTH != 128) begin : g_depth_check
    $error("FILE_DEPTH must be 128 to match the 7-bit file address");
  end

  alu_sleep_pkg::state_t s_q;
  alu_sleep_pkg::state_t s_d;
  logic [7:0] file_mem [FILE_DEPTH];

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic req;
  logic wr_commit;
  logic in_file;
  logic [6:0] file_idx;
  logic exec;
  alu_sleep_pkg::instr_t ins;
  logic [7:0] fval;
  logic [7:0] wbyte;

  assign req = wb_cyc_i & wb_stb_i & ~s_q.ack;
  assign wr_commit = wb_cyc_i & wb_stb_i & s_q.ack & wb_we_i;
  assign in_file = wb_adr_i[9];
  assign file_idx = wb_adr_i[8:2];
  assign wbyte = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;
  assign ins = {wb_dat_i[alu_sleep_pkg::IN_OPND_LSB +: 8],
                wb_dat_i[alu_sleep_pkg::IN_DEST],
                wb_dat_i[alu_sleep_pkg::IN_OP_LSB +: 4]};
  assign exec = wr_commit & wb_sel_i[0] & wb_sel_i[1] & ~s_q.sleep
                & (wb_adr_i == alu_sleep_pkg::ADR_INSTR);
  assign fval = file_mem[ins.operand[6:0]];

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  logic [8:0] diff;
  logic [4:0] ndiff;
  logic [7:0] mnd;
  logic [7:0] res;
  logic brw;
  logic wr_res;
  logic upd_cd;
  logic upd_z;
  logic [7:0] rot;

  assign rot = {s_q.carry, fval[7:1]};

  always_comb begin
    mnd = (ins.op == alu_sleep_pkg::OP_LIT_MINUS_ACC) ? ins.operand : fval;
    brw = (ins.op == alu_sleep_pkg::OP_REG_MINUS_ACC_B) & ~s_q.carry;
    diff = {1'b0, mnd} - {1'b0, s_q.acc} - {8'h00, brw};
    ndiff = {1'b0, mnd[3:0]} - {1'b0, s_q.acc[3:0]} - {4'h0, brw};
    res = diff[7:0];
    wr_res = 1'b1;
    upd_cd = 1'b0;
    upd_z = 1'b0;
    case (ins.op)
      alu_sleep_pkg::OP_ROTATE_RIGHT: begin
        res = rot;
      end
      alu_sleep_pkg::OP_LIT_MINUS_ACC,
      alu_sleep_pkg::OP_REG_MINUS_ACC,
      alu_sleep_pkg::OP_REG_MINUS_ACC_B: begin
        upd_cd = 1'b1;
        upd_z = 1'b1;
      end
      alu_sleep_pkg::OP_NIBBLE_EXCHANGE: begin
        res = {fval[3:0], fval[7:4]};
      end
      alu_sleep_pkg::OP_XOR_LITERAL: begin
        res = s_q.acc ^ ins.operand;
        upd_z = 1'b1;
      end
      alu_sleep_pkg::OP_XOR_REGISTER: begin
        res = s_q.acc ^ fval;
        upd_z = 1'b1;
      end
      default: begin
        wr_res = 1'b0;
      end
    endcase
  end

  // Literal forms always land in the accumulator.
  logic lit_op;
  logic to_acc;
  logic to_file;
  assign lit_op = (ins.op == alu_sleep_pkg::OP_LIT_MINUS_ACC) |
                  (ins.op == alu_sleep_pkg::OP_XOR_LITERAL);
  assign to_acc = exec & wr_res &
                  (lit_op | ins.dest == alu_sleep_pkg::DEST_ACC);
  assign to_file = exec & wr_res & ~lit_op &
                   (ins.dest != alu_sleep_pkg::DEST_ACC);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic wake_lvl;
  assign wake_lvl = s_q.wake_sync[1] & s_q.wake_sync[2];

  always_comb begin
    s_d = s_q;
    s_d.wake_sync = {s_q.wake_sync[1:0], wake_i};
    s_d.ack = req;
    if (s_q.sleep && wake_lvl) begin
      s_d.sleep = 1'b0;
    end
    if (!s_q.sleep) begin
      s_d.prescaler = s_q.prescaler + 8'h01;
      if (s_q.prescaler == 8'hFF) begin
        s_d.watchdog_counter = s_q.watchdog_counter + 8'h01;
      end
    end
    if (req) begin
      case (wb_adr_i)
        alu_sleep_pkg::ADR_ACC: s_d.dat = {24'h000000, s_q.acc};
        alu_sleep_pkg::ADR_STATUS: begin
          s_d.dat = 32'h00000000;
          s_d.dat[alu_sleep_pkg::ST_CARRY] = s_q.carry;
          s_d.dat[alu_sleep_pkg::ST_DIGIT] = s_q.digit_carry_flag;
          s_d.dat[alu_sleep_pkg::ST_ZERO] = s_q.zero;
          s_d.dat[alu_sleep_pkg::ST_PD] = s_q.powerdown_status_bit;
          s_d.dat[alu_sleep_pkg::ST_TO] = s_q.timeout_status_bit;
          s_d.dat[alu_sleep_pkg::ST_SLEEP] = s_q.sleep;
        end
        alu_sleep_pkg::ADR_DIR_A: s_d.dat = {24'h000000, s_q.port_a_direction};
        alu_sleep_pkg::ADR_DIR_B: s_d.dat = {24'h000000, s_q.port_b_direction};
        alu_sleep_pkg::ADR_DIR_C: s_d.dat = {24'h000000, s_q.port_c_direction};
        alu_sleep_pkg::ADR_WDT: s_d.dat = {16'h0000, s_q.prescaler,
                                           s_q.watchdog_counter};
        default: begin
          s_d.dat = in_file ? {24'h000000, file_mem[file_idx]} : 32'h00000000;
        end
      endcase
    end
    if (wr_commit && wb_sel_i[0] && !exec) begin
      if (wb_adr_i == alu_sleep_pkg::ADR_ACC) begin
        s_d.acc = wbyte;
      end
      if (wb_adr_i == alu_sleep_pkg::ADR_STATUS) begin
        s_d.carry = wbyte[alu_sleep_pkg::ST_CARRY];
        s_d.digit_carry_flag = wbyte[alu_sleep_pkg::ST_DIGIT];
        s_d.zero = wbyte[alu_sleep_pkg::ST_ZERO];
      end
    end
    if (to_acc) begin
      s_d.acc = res;
    end
    if (exec) begin
      if (ins.op == alu_sleep_pkg::OP_ROTATE_RIGHT) begin
        s_d.carry = fval[0];
      end
      if (upd_cd) begin
        s_d.carry = ~diff[8];
        s_d.digit_carry_flag = ~ndiff[4];
      end
      if (upd_z) begin
        s_d.zero = (res == 8'h00);
      end
      if (ins.op == alu_sleep_pkg::OP_LOAD_DIRECTION) begin
        case (ins.operand)
          alu_sleep_pkg::DIR_SEL_A: s_d.port_a_direction = s_q.acc;
          alu_sleep_pkg::DIR_SEL_B: s_d.port_b_direction = s_q.acc;
          alu_sleep_pkg::DIR_SEL_C: s_d.port_c_direction = s_q.acc;
          default: ;
        endcase
      end
      if (ins.op == alu_sleep_pkg::OP_SLEEP) begin
        s_d.watchdog_counter = alu_sleep_pkg::WDT_CLEAR;
        s_d.prescaler = alu_sleep_pkg::WDT_CLEAR;
        s_d.timeout_status_bit = 1'b1;
        s_d.powerdown_status_bit = 1'b0;
        s_d.sleep = 1'b1;
      end
    end
    // The oscillator flag follows the sleep state in the same cycle.
    s_d.osc_run = ~s_d.sleep;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.acc <= alu_sleep_pkg::RST_ACC;
      s_q.timeout_status_bit <= alu_sleep_pkg::RST_TO;
      s_q.powerdown_status_bit <= alu_sleep_pkg::RST_PD;
      s_q.osc_run <= alu_sleep_pkg::RST_OSC_RUN;
      s_q.port_a_direction <= alu_sleep_pkg::RST_DIR;
      s_q.port_b_direction <= alu_sleep_pkg::RST_DIR;
      s_q.port_c_direction <= alu_sleep_pkg::RST_DIR;
    end else begin
      s_q <= s_d;
    end
  end

  // File registers are written by the bus or by a routed result.
  always_ff @(posedge clk_i) begin
    if (to_file) begin
      file_mem[ins.operand[6:0]] <= res;
    end else if (wr_commit && in_file && wb_sel_i[0]) begin
      file_mem[file_idx] <= wbyte;
    end
  end

  assign wb_dat_o = s_q.dat;
  assign wb_ack_o = s_q.ack;
  assign osc_run_o = s_q.osc_run;
  assign port_a_direction_o = s_q.port_a_direction;
  assign port_b_direction_o = s_q.port_b_direction;
  assign port_c_direction_o = s_q.port_c_direction;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_rotate_carry: assert property (
    exec && ins.op == alu_sleep_pkg::OP_ROTATE_RIGHT |=>
      s_q.carry == $past(fval[0]))
    else $error("rotate did not move bit 0 into carry");
  a_dest_select: assert property (
    exec && wr_res && !lit_op && ins.dest |=> s_q.acc == $past(s_q.acc))
    else $error("file destination changed the accumulator");
  a_sleep_flags: assert property (
    exec && ins.op == alu_sleep_pkg::OP_SLEEP |=>
      s_q.timeout_status_bit && !s_q.powerdown_status_bit &&
      s_q.watchdog_counter == 8'h00 && s_q.prescaler == 8'h00)
    else $error("sleep did not set the status and watchdog");
  a_sleep_halt: assert property (
    s_q.sleep && !wake_lvl |=> s_q.sleep && !osc_run_o &&
      $stable(s_q.acc) && $stable(s_q.prescaler))
    else $error("core ran while asleep");
  a_sub_carry: assert property (
    exec && upd_cd |=> s_q.carry == (9'($past(mnd)) >=
      9'($past(s_q.acc)) + 9'($past(brw))))
    else $error("subtract carry wrong");
  a_sub_value: assert property (
    exec && ins.op == alu_sleep_pkg::OP_LIT_MINUS_ACC |=>
      s_q.acc == 8'($past(ins.operand) - $past(s_q.acc)))
    else $error("literal minus accumulator wrong");
  a_swap_flags: assert property (
    exec && ins.op == alu_sleep_pkg::OP_NIBBLE_EXCHANGE |=>
      $stable(s_q.carry) && $stable(s_q.zero) &&
      $stable(s_q.digit_carry_flag))
    else $error("nibble exchange touched a flag");
  a_dir_load: assert property (
    exec && ins.op == alu_sleep_pkg::OP_LOAD_DIRECTION &&
      ins.operand == alu_sleep_pkg::DIR_SEL_B |=>
      port_b_direction_o == $past(s_q.acc) &&
      $stable(port_a_direction_o) && $stable(port_c_direction_o))
    else $error("direction load went to the wrong port");
  a_xor_zero: assert property (
    exec && ins.op == alu_sleep_pkg::OP_XOR_LITERAL |=>
      s_q.zero == (s_q.acc == 8'h00) && $stable(s_q.carry))
    else $error("xor literal zero flag wrong");
  a_bus_ack: assert property (
    req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle");

endmodule

// File: tb/alu_sleep_tb.sv
/*
  Self-checking testbench for the instruction execution block.
  Assumes the block answers each classic Wishbone access with one ack.
*/
`timescale 1ns/1ns
module alu_sleep_tb;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wake_i;
  logic wb_ack_o, osc_run_o;
  logic [9:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [7:0] dir_a, dir_b, dir_c, ea, eb, ec;
  int n_mismatch = 0;
  int n_checks = 0;

  alu_sleep dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wake_i(wake_i), .osc_run_o(osc_run_o),
    .port_a_direction_o(dir_a), .port_b_direction_o(dir_b),
    .port_c_direction_o(dir_c));

  // ----------------------------------------------------------------
  // Clock, checking and reporting
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // ----------------------------------------------------------------
  // Bus access tasks
  // ----------------------------------------------------------------
  // One classic cycle; held until ack is sampled high, then released.
  task automatic bus(input logic we, input logic [9:0] adr,
                     input logic [31:0] dat, input logic [3:0] sel);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    if (i == 20) begin
      n_mismatch++;
      $display("mismatch wb_ack_o expected 1 seen 0");
      summarize();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  function automatic logic [9:0] fa(input int n);
    return alu_sleep_pkg::ADR_FILE_BASE + 10'(4 * n);
  endfunction

  task automatic wr(input logic [9:0] adr, input logic [7:0] v);
    bus(1'b1, adr, {24'h000000, v}, 4'h1);
  endtask

  task automatic rdc(input string name, input logic [9:0] adr,
                     input logic [7:0] mask, input logic [7:0] exp);
    bus(1'b0, adr, 32'h00000000, 4'hF);
    check(name, {24'h000000, rd[7:0] & mask}, {24'h000000, exp});
  endtask

  task automatic exec(input logic [3:0] op, input logic dest,
                      input logic [7:0] opnd);
    bus(1'b1, alu_sleep_pkg::ADR_INSTR,
        {16'h0000, opnd, 3'h0, dest, op}, 4'h3);
  endtask

  // Sets operands, runs one subtract and compares result and flags.
  task automatic sub_case(input logic [3:0] op, input logic [7:0] a,
                          input logic [7:0] b, input logic cin,
                          input logic dest);
    logic bin;
    logic [8:0] full;
    logic [4:0] nib;
    logic to_acc;
    bin = (op == alu_sleep_pkg::OP_REG_MINUS_ACC_B) ? ~cin : 1'b0;
    full = {1'b0, b} - {1'b0, a} - 9'(bin);
    nib = {1'b0, b[3:0]} - {1'b0, a[3:0]} - 5'(bin);
    to_acc = (op == alu_sleep_pkg::OP_LIT_MINUS_ACC) || !dest;
    wr(alu_sleep_pkg::ADR_ACC, a);
    wr(alu_sleep_pkg::ADR_STATUS, {7'h00, cin});
    wr(fa(9), b);
    exec(op, dest, (op == alu_sleep_pkg::OP_LIT_MINUS_ACC) ? b : 8'h09);
    rdc("sub acc", alu_sleep_pkg::ADR_ACC, 8'hFF,
        to_acc ? full[7:0] : a);
    rdc("sub file", fa(9), 8'hFF, to_acc ? b : full[7:0]);
    rdc("sub flags", alu_sleep_pkg::ADR_STATUS, 8'h07,
        {5'h00, full[7:0] == 8'h00, ~nib[4], ~full[8]});
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 10'h000;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h00000000;
    wake_i = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc("status reset", alu_sleep_pkg::ADR_STATUS, 8'h3F, 8'h18);
    check("dir reset", {8'h00, dir_a, dir_b, dir_c}, 32'h00FFFFFF);
    $display("reset test done");

    wr(alu_sleep_pkg::ADR_STATUS, 8'h04);
    wr(fa(5), 8'h03);
    exec(alu_sleep_pkg::OP_ROTATE_RIGHT, 1'b1, 8'h05);
    rdc("rot file", fa(5), 8'hFF, 8'h01);
    rdc("rot flags", alu_sleep_pkg::ADR_STATUS, 8'h07, 8'h05);
    exec(alu_sleep_pkg::OP_ROTATE_RIGHT, 1'b0, 8'h05);
    rdc("rot acc", alu_sleep_pkg::ADR_ACC, 8'hFF, 8'h80);
    rdc("rot keep", fa(5), 8'hFF, 8'h01);
    rdc("rot flags2", alu_sleep_pkg::ADR_STATUS, 8'h07, 8'h05);
    $display("rotate test done");

    sub_case(alu_sleep_pkg::OP_LIT_MINUS_ACC, 8'h10, 8'h10, 1'b0, 1'b1);
    sub_case(alu_sleep_pkg::OP_LIT_MINUS_ACC, 8'h06, 8'h05, 1'b1, 1'b0);
    sub_case(alu_sleep_pkg::OP_REG_MINUS_ACC, 8'h01, 8'h20, 1'b0, 1'b1);
    sub_case(alu_sleep_pkg::OP_REG_MINUS_ACC, 8'h81, 8'h80, 1'b1, 1'b0);
    sub_case(alu_sleep_pkg::OP_REG_MINUS_ACC_B, 8'h0F, 8'h10, 1'b0, 1'b1);
    sub_case(alu_sleep_pkg::OP_REG_MINUS_ACC_B, 8'h0F, 8'h10, 1'b1, 1'b0);
    $display("subtract test done");

    wr(alu_sleep_pkg::ADR_STATUS, 8'h07);
    wr(fa(3), 8'hA5);
    exec(alu_sleep_pkg::OP_NIBBLE_EXCHANGE, 1'b0, 8'h03);
    rdc("swap acc", alu_sleep_pkg::ADR_ACC, 8'hFF, 8'h5A);
    exec(alu_sleep_pkg::OP_NIBBLE_EXCHANGE, 1'b1, 8'h03);
    rdc("swap file", fa(3), 8'hFF, 8'h5A);
    rdc("swap flags", alu_sleep_pkg::ADR_STATUS, 8'h07, 8'h07);
    $display("swap test done");

    ea = 8'hFF;
    eb = 8'hFF;
    ec = 8'hFF;
    for (int o = 4; o <= 8; o++) begin
      wr(alu_sleep_pkg::ADR_ACC, 8'h30 + 8'(o));
      exec(alu_sleep_pkg::OP_LOAD_DIRECTION, 1'b0, 8'(o));
      if (o == 5) ea = 8'h35;
      if (o == 6) eb = 8'h36;
      if (o == 7) ec = 8'h37;
      @(posedge clk_i);
      check("dir ports", {8'h00, dir_a, dir_b, dir_c},
            {8'h00, ea, eb, ec});
    end
    rdc("dir c reg", alu_sleep_pkg::ADR_DIR_C, 8'hFF, 8'h37);
    rdc("dir flags", alu_sleep_pkg::ADR_STATUS, 8'h07, 8'h07);
    $display("direction test done");

    wr(alu_sleep_pkg::ADR_STATUS, 8'h03);
    wr(alu_sleep_pkg::ADR_ACC, 8'h5A);
    exec(alu_sleep_pkg::OP_XOR_LITERAL, 1'b1, 8'h5A);
    rdc("xorl acc", alu_sleep_pkg::ADR_ACC, 8'hFF, 8'h00);
    rdc("xorl flags", alu_sleep_pkg::ADR_STATUS, 8'h07, 8'h07);
    wr(alu_sleep_pkg::ADR_ACC, 8'h0F);
    wr(fa(7), 8'hF1);
    exec(alu_sleep_pkg::OP_XOR_REGISTER, 1'b1, 8'h07);
    rdc("xorf file", fa(7), 8'hFF, 8'hFE);
    rdc("xorf acc", alu_sleep_pkg::ADR_ACC, 8'hFF, 8'h0F);
    rdc("xorf flags", alu_sleep_pkg::ADR_STATUS, 8'h07, 8'h03);
    $display("xor test done");

    repeat (300) @(posedge clk_i);
    exec(alu_sleep_pkg::OP_SLEEP, 1'b0, 8'h00);
    rdc("wdt count", alu_sleep_pkg::ADR_WDT, 8'hFF, 8'h00);
    check("wdt presc", {24'h000000, rd[15:8]}, 32'h00000000);
    rdc("sleep status", alu_sleep_pkg::ADR_STATUS, 8'h38, 8'h30);
    check("osc run", {31'h0, osc_run_o}, 32'h00000000);
    exec(alu_sleep_pkg::OP_XOR_LITERAL, 1'b0, 8'hFF);
    rdc("asleep acc", alu_sleep_pkg::ADR_ACC, 8'hFF, 8'h0F);
    @(posedge clk_i);
    wake_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    wake_i <= 1'b0;
    for (int i = 0; i < 20 && osc_run_o !== 1'b1; i++) @(posedge clk_i);
    check("osc wake", {31'h0, osc_run_o}, 32'h00000001);
    rdc("awake status", alu_sleep_pkg::ADR_STATUS, 8'h20, 8'h00);
    $display("sleep test done");
    summarize();
  end
endmodule
